/* File: converter_mode_control_select.sv */
// Control-mode selection, pin/register merge and calibration trigger
`timescale 1ns/1ps
module converter_mode_control_select (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    // Control pins
    input  wire logic        i_extended_control_select_n,
    input  wire logic        i_dual_edge_sel,
    input  wire logic        i_single_bus_select,
    input  wire logic        i_output_phase_select,
    input  wire logic        i_cal_pin,
    input  wire logic        i_i_chan_powerdown,
    input  wire logic        i_q_chan_powerdown,
    // Output data-rate setting from the output stage
    input  wire logic        i_ddr_output,
    // Register port from the serial port logic
    input  wire logic        i_reg_wr_en,
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    // Mode status
    output logic             o_register_control_mode,
    output logic             o_serial_port_enable,
    // Sampling configuration
    output logic             o_dual_edge_mode,
    output logic             o_dual_edge_q_input,
    output logic             o_i_sample_falling,
    output logic             o_q_sample_falling,
    // Output bus configuration
    output logic             o_single_bus,
    output logic             o_half_rate_words,
    output logic      [2:0]  o_i_input_buses,
    output logic      [2:0]  o_q_input_buses,
    output logic      [1:0]  o_i_launch_phase,
    output logic      [1:0]  o_q_launch_phase,
    // Calibration and power down
    output logic             o_cal_start,
    output logic             o_i_powered_down,
    output logic             o_q_powered_down,
    output logic             o_i_bus_oe
);

    typedef enum logic [1:0] {
        CAL_LOW_COUNT,
        CAL_PRIMED,
        CAL_HIGH_COUNT,
        CAL_WAIT_LOW
    } cal_state_t;

    // Synchronised pins and on-chip data-rate setting
    logic [6:0]  pins_s;
    logic        ece_s;
    logic        des_s;
    logic        ndm_s;
    logic        phase_s;
    logic        cal_s;
    logic        pdi_s;
    logic        pdq_s;
    logic        ddr_s;

    // Register bank
    logic [15:0] cfg      [16];
    logic [15:0] next_cfg [16];
    logic [15:0] main_cfg;

    // Merged controls
    logic        reg_mode;
    logic        des_eff;
    logic        qsel_eff;
    logic        phase_eff;
    logic        cal_eff;
    logic        pdi_eff;
    logic        pdq_eff;

    // Calibration detector
    cal_state_t  cal_state;
    cal_state_t  next_cal_state;
    logic [7:0]  cal_cnt;
    logic [7:0]  next_cal_cnt;
    logic        next_cal_start;

    // Next output values
    logic [15:0] next_rdata;
    logic        next_reg_mode;
    logic        next_des;
    logic        next_qsel;
    logic        next_single;
    logic [2:0]  next_i_buses;
    logic [2:0]  next_q_buses;
    logic [1:0]  next_phase;
    logic        next_pdi;
    logic        next_pdq;

    pin_sync #(
        .WIDTH (7)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_async   ({i_extended_control_select_n, i_dual_edge_sel,
                     i_single_bus_select, i_output_phase_select,
                     i_cal_pin, i_i_chan_powerdown, i_q_chan_powerdown}),
        .o_sync    (pins_s)
    );

    // Split synchronised pins; data-rate setting is on-chip, same clock
    assign {ece_s, des_s, ndm_s, phase_s, cal_s, pdi_s, pdq_s} = pins_s;
    assign ddr_s = i_ddr_output;

    // Register bank next values
    always_comb begin
        main_cfg = cfg[conv_mode_pkg::MAIN_CONFIGURATION_ADDR];
        next_cfg = cfg;
        if (ece_s) begin
            next_cfg = '{default: conv_mode_pkg::REG_DEFAULT};
        end else if (i_reg_wr_en) begin
            next_cfg[i_reg_addr] = i_reg_wdata;
        end
        next_rdata = cfg[i_reg_addr];
    end

    // Register bank storage
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg <= '{default: conv_mode_pkg::REG_DEFAULT};
        end else begin
            cfg <= next_cfg;
        end
    end

    // Merge pins with register bits
    always_comb begin
        // select pin high is pin mode
        reg_mode  = !ece_s;
        des_eff   = des_s |
                    (reg_mode & main_cfg[conv_mode_pkg::DUAL_EDGE_BIT]);
        // Q select only in register mode
        qsel_eff  = reg_mode & main_cfg[conv_mode_pkg::Q_INPUT_SEL_BIT];
        phase_eff = phase_s |
                    (reg_mode & main_cfg[conv_mode_pkg::PHASE_SEL_BIT]);
        cal_eff   = cal_s | (reg_mode & main_cfg[conv_mode_pkg::CAL_BIT]);
        pdi_eff   = pdi_s | (reg_mode & main_cfg[conv_mode_pkg::I_PD_BIT]);
        pdq_eff   = pdq_s | (reg_mode & main_cfg[conv_mode_pkg::Q_PD_BIT]);
    end

    // Calibration pulse qualification
    always_comb begin
        next_cal_state = cal_state;
        next_cal_cnt   = cal_cnt;
        next_cal_start = 1'b0;
        // low for minimum, then high for minimum
        unique case (cal_state)
            CAL_LOW_COUNT: begin
                if (cal_eff) begin
                    next_cal_cnt = '0;
                end else if (cal_cnt + 8'h01 >=
                             conv_mode_pkg::CAL_LOW_MIN) begin
                    next_cal_state = CAL_PRIMED;
                    next_cal_cnt   = '0;
                end else begin
                    next_cal_cnt = cal_cnt + 8'h01;
                end
            end
            CAL_PRIMED: begin
                if (cal_eff) begin
                    next_cal_state = CAL_HIGH_COUNT;
                    next_cal_cnt   = 8'h01;
                end
            end
            CAL_HIGH_COUNT: begin
                if (!cal_eff) begin
                    next_cal_state = CAL_LOW_COUNT;
                    next_cal_cnt   = 8'h01;
                end else if (cal_cnt + 8'h01 >=
                             conv_mode_pkg::CAL_HIGH_MIN) begin
                    next_cal_state = CAL_WAIT_LOW;
                    next_cal_cnt   = '0;
                    next_cal_start = 1'b1;
                end else begin
                    next_cal_cnt = cal_cnt + 8'h01;
                end
            end
            CAL_WAIT_LOW: begin
                // Held high in normal use, so no retrigger until low
                if (!cal_eff) begin
                    next_cal_state = CAL_LOW_COUNT;
                    next_cal_cnt   = 8'h01;
                end
            end
        endcase
    end

    // Calibration detector registers
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cal_state   <= CAL_LOW_COUNT;
            cal_cnt     <= '0;
            o_cal_start <= 1'b0;
        end else begin
            cal_state   <= next_cal_state;
            cal_cnt     <= next_cal_cnt;
            o_cal_start <= next_cal_start;
        end
    end

    // Output configuration decode
    always_comb begin
        next_reg_mode = reg_mode;
        next_des      = des_eff;
        next_qsel     = des_eff & qsel_eff;
        next_pdi      = pdi_eff;
        next_pdq      = pdq_eff;
        next_single   = ndm_s;
        if (des_eff) begin
            next_i_buses = qsel_eff ? conv_mode_pkg::BUS_NONE :
                           (ndm_s ? conv_mode_pkg::BUS_TWO :
                                    conv_mode_pkg::BUS_FOUR);
            next_q_buses = !qsel_eff ? conv_mode_pkg::BUS_NONE :
                           (ndm_s ? conv_mode_pkg::BUS_TWO :
                                    conv_mode_pkg::BUS_FOUR);
        end else begin
            next_i_buses = pdi_eff ? conv_mode_pkg::BUS_NONE :
                           (ndm_s ? conv_mode_pkg::BUS_ONE :
                                    conv_mode_pkg::BUS_TWO);
            next_q_buses = pdq_eff ? conv_mode_pkg::BUS_NONE :
                           (ndm_s ? conv_mode_pkg::BUS_ONE :
                                    conv_mode_pkg::BUS_TWO);
        end
        if (ddr_s) begin
            next_phase = phase_eff ? conv_mode_pkg::PHASE_DDR_90 :
                                     conv_mode_pkg::PHASE_DDR_0;
        end else begin
            next_phase = phase_eff ? conv_mode_pkg::PHASE_SDR_FALL :
                                     conv_mode_pkg::PHASE_SDR_RISE;
        end
    end

    // Output registers
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata             <= '0;
            o_register_control_mode <= 1'b0;
            o_serial_port_enable    <= 1'b0;
            o_dual_edge_mode        <= 1'b0;
            o_dual_edge_q_input     <= 1'b0;
            o_i_sample_falling      <= 1'b0;
            o_q_sample_falling      <= 1'b0;
            o_single_bus            <= 1'b0;
            o_half_rate_words       <= 1'b1;
            o_i_input_buses         <= conv_mode_pkg::BUS_TWO;
            o_q_input_buses         <= conv_mode_pkg::BUS_TWO;
            o_i_launch_phase        <= conv_mode_pkg::PHASE_SDR_RISE;
            o_q_launch_phase        <= conv_mode_pkg::PHASE_SDR_RISE;
            o_i_powered_down        <= 1'b0;
            o_q_powered_down        <= 1'b0;
            o_i_bus_oe              <= 1'b0;
        end else begin
            o_reg_rdata             <= next_rdata;
            o_register_control_mode <= next_reg_mode;
            // serial port off in pin mode
            o_serial_port_enable    <= next_reg_mode;
            o_dual_edge_mode        <= next_des;
            o_dual_edge_q_input     <= next_qsel;
            // I on rising, Q on falling edge in dual-edge mode
            o_i_sample_falling      <= 1'b0;
            o_q_sample_falling      <= next_des;
            o_single_bus            <= next_single;
            // demux words leave at half rate
            o_half_rate_words       <= !next_single;
            o_i_input_buses         <= next_i_buses;
            o_q_input_buses         <= next_q_buses;
            o_i_launch_phase        <= next_phase;
            o_q_launch_phase        <= next_phase;
            o_i_powered_down        <= next_pdi;
            o_q_powered_down        <= next_pdq;
            // I buses float while I powered down
            o_i_bus_oe              <= !next_pdi;
        end
    end

    // Checks on the decoded configuration
    pin_mode_serial_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        ece_s |=> !o_serial_port_enable && !o_register_control_mode)
        else $error("serial port active in pin mode");
    reg_default_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        ece_s |=> main_cfg == conv_mode_pkg::REG_DEFAULT)
        else $error("registers not restored in pin mode");
    des_pin_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        des_s |=> o_dual_edge_mode && o_q_sample_falling)
        else $error("dual-edge pin ignored");
    q_pin_mode_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_dual_edge_q_input |-> o_register_control_mode)
        else $error("Q input chosen in pin mode");
    des_bit_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !ece_s && main_cfg[conv_mode_pkg::DUAL_EDGE_BIT] |=> o_dual_edge_mode)
        else $error("dual-edge bit ignored");
    demux_pin_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        ##1 o_single_bus == $past(ndm_s))
        else $error("demux not following its pin");
    des_buses_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_dual_edge_mode && !o_dual_edge_q_input && !o_single_bus
        |-> o_i_input_buses == conv_mode_pkg::BUS_FOUR &&
            o_q_input_buses == conv_mode_pkg::BUS_NONE)
        else $error("wrong bus count in dual-edge demux");
    phase_equal_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_i_launch_phase == o_q_launch_phase)
        else $error("channel phases differ");
    cal_pulse_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_cal_start |-> $past(cal_eff) && $past(cal_eff, 2) ##1 !o_cal_start)
        else $error("bad calibration start pulse");
    cal_or_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !ece_s && main_cfg[conv_mode_pkg::CAL_BIT] |-> cal_eff)
        else $error("calibration bit not merged");
    pd_float_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !ece_s && main_cfg[conv_mode_pkg::I_PD_BIT]
        |=> o_i_powered_down && !o_i_bus_oe)
        else $error("I buses driven while powered down");

endmodule

/* File: conv_mode_pkg.sv */
// Shared constants for the converter control-mode selection block
package conv_mode_pkg;

    // Register bank geometry
    localparam int          REG_COUNT   = 16;
    localparam int          REG_WIDTH   = 16;
    localparam int          ADDR_WIDTH  = 4;

    // Register offsets
    localparam logic [3:0]  MAIN_CONFIGURATION_ADDR = 4'h0;

    // Field positions in the main configuration register
    localparam int          CAL_BIT         = 15;
    localparam int          PHASE_SEL_BIT   = 14;
    localparam int          I_PD_BIT        = 11;
    localparam int          Q_PD_BIT        = 10;
    localparam int          DUAL_EDGE_BIT   = 7;
    localparam int          Q_INPUT_SEL_BIT = 6;

    // Reset value of every configuration register
    localparam logic [15:0] REG_DEFAULT = 16'h0000;

    // Calibration pin qualification counts, in input clock cycles
    localparam int          CAL_CNT_WIDTH = 8;
    localparam logic [7:0]  CAL_LOW_MIN   = 8'h10;
    localparam logic [7:0]  CAL_HIGH_MIN  = 8'h10;

    // Number of output buses carrying one input
    localparam logic [2:0]  BUS_NONE = 3'h0;
    localparam logic [2:0]  BUS_ONE  = 3'h1;
    localparam logic [2:0]  BUS_TWO  = 3'h2;
    localparam logic [2:0]  BUS_FOUR = 3'h4;

    // Data launch phase relative to the output clock
    localparam logic [1:0]  PHASE_DDR_0   = 2'h0;
    localparam logic [1:0]  PHASE_DDR_90  = 2'h1;
    localparam logic [1:0]  PHASE_SDR_RISE = 2'h2;
    localparam logic [1:0]  PHASE_SDR_FALL = 2'h3;

endpackage

/* File: pin_sync.sv */
// Two-stage synchroniser for a group of static control pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_nrst,
    // Pins and synchronised copy
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    // First stage feeds only the second stage
    always_comb begin
        next_stage1 = i_async;
        next_sync   = stage1;
    end

    // Register both stages
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= next_stage1;
            o_sync <= next_sync;
        end
    end

endmodule

/* File: board_ctrl.sv */
// Board controller model that drives the static control pins
`timescale 1ns/1ps
module board_ctrl #(
    parameter int LOW_LEN = 24
) (
    // Clock
    input  wire logic       i_clk_sys,
    // Requested pin levels and calibration request
    input  wire logic [5:0] i_levels,
    input  wire logic       i_cal_go,
    input  wire logic [7:0] i_high_len,
    // Pins towards the converter
    output logic      [5:0] o_pins,
    output logic            o_cal_pin
);
    initial o_pins = 6'h01;
    initial o_cal_pin = 1'b1;

    // Static pins follow the requested levels
    always @(posedge i_clk_sys) begin
        o_pins <= i_levels;
    end

    always @(posedge i_clk_sys) begin
        if (i_cal_go) begin
            o_cal_pin <= 1'b0;
            repeat (LOW_LEN) @(posedge i_clk_sys);
            o_cal_pin <= 1'b1;
            repeat (i_high_len) @(posedge i_clk_sys);
            o_cal_pin <= 1'b0;
            repeat (LOW_LEN) @(posedge i_clk_sys);
            o_cal_pin <= 1'b1;
        end
    end
endmodule

/* File: converter_mode_control_select_test.sv */
// Self-checking bench for the control-mode selection block
`timescale 1ns/1ps
module converter_mode_control_select_test;
    logic        clk, nrst, go, ddr, wr_en, rcm, spe, dem, qin, ifl, qfl;
    logic        sgl, half, cal, ipd, qpd, oe;
    logic [5:0]  lvl, pins;
    logic [7:0]  hlen;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata;
    logic [2:0]  ib, qb;
    logic [1:0]  iph, qph;
    logic        cpin;
    int          mismatches, n_compared, pulses;

    // Clock generation
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    board_ctrl board_ctrl_inst (
        .i_clk_sys(clk), .i_levels(lvl), .i_cal_go(go),
        .i_high_len(hlen), .o_pins(pins), .o_cal_pin(cpin));

    converter_mode_control_select converter_mode_control_select_inst (
        .i_clk_sys(clk), .i_nrst(nrst),
        .i_extended_control_select_n(pins[0]), .i_dual_edge_sel(pins[1]),
        .i_single_bus_select(pins[2]), .i_output_phase_select(pins[3]),
        .i_cal_pin(cpin), .i_i_chan_powerdown(pins[4]),
        .i_q_chan_powerdown(pins[5]), .i_ddr_output(ddr),
        .i_reg_wr_en(wr_en), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_register_control_mode(rcm),
        .o_serial_port_enable(spe), .o_dual_edge_mode(dem),
        .o_dual_edge_q_input(qin), .o_i_sample_falling(ifl),
        .o_q_sample_falling(qfl), .o_single_bus(sgl),
        .o_half_rate_words(half), .o_i_input_buses(ib),
        .o_q_input_buses(qb), .o_i_launch_phase(iph),
        .o_q_launch_phase(qph), .o_cal_start(cal),
        .o_i_powered_down(ipd), .o_q_powered_down(qpd), .o_i_bus_oe(oe));

    // Count calibration start pulses
    always @(posedge clk) begin
        if (cal === 1'b1) pulses++;
    end

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1;
        chk("rdata", rdata, e);
    endtask

    // Run one calibration sequence and count start pulses
    task automatic cal_run(input logic [7:0] h, input int e);
        @(posedge clk);
        pulses = 0;
        hlen <= h;
        go   <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (90 + int'(h)) @(posedge clk);
        chk("cal_pulses", 16'(pulses), 16'(e));
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog
    initial begin
        #400000;
        mismatches++;
        results();
    end

    // Main sequence
    initial begin
        logic [2:0] eb;
        mismatches = 0; n_compared = 0; pulses = 0;
        nrst = 1'b0; lvl = 6'h05; go = 1'b0; hlen = 8'h05; ddr = 1'b1;
        wr_en = 1'b0; addr = 4'h0; wdata = 16'h0000;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        settle();
        chk("reg_mode", rcm, 0);
        chk("serial_en", spe, 0);
        wr(4'h0, 16'hffff);
        rd(4'h0, 16'h0000);
        @(posedge clk);
        lvl[1] <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("sync_delay", dem, 0);
        @(posedge clk);
        #1;
        chk("sync_arrive", dem, 1);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            lvl[1] <= k[0];
            lvl[2] <= k[1];
            settle();
            eb = k[1] ? 3'h1 : 3'h2;
            if (k[0]) eb = eb << 1;
            chk("dual_edge", dem, k[0]);
            chk("q_falling", qfl, k[0]);
            chk("i_falling", ifl, 0);
            chk("q_input", qin, 0);
            chk("i_buses", ib, eb);
            chk("q_buses", qb, k[0] ? 3'h0 : eb);
            chk("single_bus", sgl, k[1]);
            chk("half_rate", half, !k[1]);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            ddr    <= k[0];
            lvl[3] <= k[1];
            settle();
            chk("i_phase", iph, {!k[0], k[1]});
            chk("q_phase", qph, {!k[0], k[1]});
        end
        @(posedge clk);
        lvl <= 6'h00;
        ddr <= 1'b1;
        settle();
        chk("reg_mode", rcm, 1);
        chk("serial_en", spe, 1);
        for (int a = 1; a < 16; a++) wr(4'(a), 16'h1111 * 16'(a));
        for (int a = 1; a < 16; a++) rd(4'(a), 16'h1111 * 16'(a));
        wr(4'h0, 16'h0080);
        settle();
        chk("dual_edge", dem, 1);
        chk("i_buses", ib, 3'h4);
        wr(4'h0, 16'h00c0);
        settle();
        chk("q_input", qin, 1);
        chk("q_buses", qb, 3'h4);
        chk("i_buses", ib, 3'h0);
        wr(4'h0, 16'h4000);
        settle();
        chk("i_phase", iph, conv_mode_pkg::PHASE_DDR_90);
        wr(4'h0, 16'h3fff);
        settle();
        chk("single_bus", sgl, 0);
        chk("half_rate", half, 1);
        wr(4'h0, 16'h0800);
        settle();
        chk("i_pd", ipd, 1);
        chk("i_oe", oe, 0);
        chk("q_pd", qpd, 0);
        wr(4'h0, 16'h0000);
        lvl[5] <= 1'b1;
        settle();
        chk("q_pd", qpd, 1);
        chk("i_oe", oe, 1);
        @(posedge clk);
        lvl[5] <= 1'b0;
        cal_run(8'h05, 1);
        cal_run(8'h28, 2);
        wr(4'h0, 16'h8000);
        cal_run(8'h28, 0);
        @(posedge clk);
        lvl[0] <= 1'b1;
        settle();
        @(posedge clk);
        lvl[0] <= 1'b0;
        settle();
        rd(4'h5, 16'h0000);
        rd(4'h0, 16'h0000);
        results();
    end
endmodule
